// file: pocc_params.svh
`ifndef POCC_PARAMS_SVH
`define POCC_PARAMS_SVH

// Register indices; byte address is four times the index
`define POCC_IDX_CFG 16'he610
`define POCC_IDX_PH_A 16'he614
`define POCC_IDX_PH_B 16'he615
`define POCC_IDX_PH_C 16'he616
`define POCC_IDX_SNAP1 16'he620
`define POCC_IDX_SNAP2 16'he621
`define POCC_IDX_SNAP3 16'he622

// Pulse output configuration fields
`define POCC_SEL1_LSB 0
`define POCC_SEL2_LSB 3
`define POCC_SEL3_LSB 6
`define POCC_DIS_LSB 9
`define POCC_LATCH_LSB 12
`define POCC_CFG_MASK 16'h7fff
`define POCC_CFG_RST 16'h0e00

// Phase compensation field
`define POCC_COMP_W 10
`define POCC_COMP_RST 10'h000
`define POCC_ALIAS1_LO 10'h180
`define POCC_ALIAS1_HI 10'h1ff
`define POCC_ALIAS1_OFS 10'h080
`define POCC_ALIAS2_LO 10'h240
`define POCC_ALIAS2_BASE 10'h180

// Width of the energy and power words
`define POCC_ENERGY_W 32
`define POCC_POWER_W 24

`endif

// file: pocc_pkg.sv
package pocc_pkg;

   typedef enum logic [2:0] {
      POCC_SRC_ACT = 3'b000,
      POCC_SRC_REACT = 3'b001,
      POCC_SRC_APP = 3'b010,
      POCC_SRC_FACT = 3'b011,
      POCC_SRC_FREACT = 3'b100,
      POCC_SRC_RSV5 = 3'b101,
      POCC_SRC_RSV6 = 3'b110,
      POCC_SRC_RSV7 = 3'b111
   } pocc_src_t;

   typedef enum logic [1:0] {
      POCC_BUS_IDLE = 2'b00,
      POCC_BUS_READ = 2'b01,
      POCC_BUS_ACK = 2'b10
   } pocc_bus_st_t;

endpackage : pocc_pkg

// file: pocc_snap_mem.sv
`timescale 1ns/100ps
`include "pocc_params.svh"

module pocc_snap_mem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] we,
   input wire logic [`POCC_ENERGY_W-1:0] wdata [3],
   input wire logic [1:0] rd_addr,
   output logic [`POCC_ENERGY_W-1:0] rd_data
);

   logic [`POCC_ENERGY_W-1:0] mem_q [3];

   ////////////////////////////////////////////////////////////////////////
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_entry
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_q[gi] <= '0;
            end else if (we[gi]) begin
               mem_q[gi] <= wdata[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Out of range index reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (rd_addr < 2'h3) begin
         rd_data <= mem_q[rd_addr];
      end else begin
         rd_data <= '0;
      end
   end

endmodule : pocc_snap_mem

// file: pocc_top.sv
`timescale 1ns/100ps
`include "pocc_params.svh"

// Overview of operation
// - A reserved source code on output three stops all pulses there.
// - Bit 9, reset to one, silences output one while its converter runs.
// - Bit 10, reset to one, silences output two while its converter runs.
// - Bit 11, reset to one, silences output three while its converter runs.
// - Bits 12 to 14 make each converter's pulse capture its energy word, even with the pin silenced.
// - Bit 15 of the configuration is reserved and does nothing.
// - Each compensation register keeps ten low bits; the rest are void.
// - Values 384 to 511 act like 256 to 383.
// - Values 576 to 1023 act like 384 to 511.
// - Source code 001 feeds output three with total reactive power.
// - Source code 010 feeds output three with apparent power.
module pocc_top (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [17:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic DFC1_PULSE,
   input wire logic DFC2_PULSE,
   input wire logic DFC3_PULSE,
   input wire logic [`POCC_ENERGY_W-1:0] ENERGY1,
   input wire logic [`POCC_ENERGY_W-1:0] ENERGY2,
   input wire logic [`POCC_ENERGY_W-1:0] ENERGY3,
   input wire logic [`POCC_POWER_W-1:0] SUM_ACT,
   input wire logic [`POCC_POWER_W-1:0] SUM_REACT,
   input wire logic [`POCC_POWER_W-1:0] SUM_APP,
   input wire logic [`POCC_POWER_W-1:0] SUM_FACT,
   input wire logic [`POCC_POWER_W-1:0] SUM_FREACT,
   output logic PULSE_OUTPUT_1,
   output logic PULSE_OUTPUT_2,
   output logic PULSE_OUTPUT_3,
   output logic [`POCC_POWER_W-1:0] PULSE3_POWER,
   output logic [2:0] PULSE1_SOURCE,
   output logic [2:0] PULSE2_SOURCE,
   output logic [`POCC_COMP_W-1:0] PHASE_A_COMP_EFF,
   output logic [`POCC_COMP_W-1:0] PHASE_B_COMP_EFF,
   output logic [`POCC_COMP_W-1:0] PHASE_C_COMP_EFF
);
   import pocc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   pocc_bus_st_t st_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [15:0] cfg_q;
   logic [`POCC_COMP_W-1:0] comp_q [3];
   logic [`POCC_COMP_W-1:0] comp_eff_q [3];
   logic [15:0] idx;
   logic wr_en;
   logic [2:0] comp_hit;
   logic snap_hit;
   logic [1:0] snap_addr;
   logic [`POCC_ENERGY_W-1:0] snap_rd;
   logic [2:0] dfc;
   logic [2:0] dfc_q;
   logic [2:0] pulse_q;
   logic [2:0] snap_we;
   logic [`POCC_ENERGY_W-1:0] energy [3];
   logic [`POCC_POWER_W-1:0] p3_pow_q;
   logic [2:0] src1_q;
   logic [2:0] src2_q;
   pocc_src_t src3;
   logic src3_ok;
   logic [`POCC_POWER_W-1:0] p3_pow_d;
   logic [31:0] rd_d;
   // Bus decode hit and write strobes per register
   logic cfg_hit;
   logic cfg_wr;
   logic [2:0] comp_wr;

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [15:0] merge16(
      input logic [15:0] old_v,
      input logic [31:0] data,
      input logic [3:0] sel
   );
      logic [15:0] res;
      res = old_v;
      if (sel[0]) begin
         res[7:0] = data[7:0];
      end
      if (sel[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction : merge16

   function automatic logic [`POCC_COMP_W-1:0] alias_comp(
      input logic [`POCC_COMP_W-1:0] v
   );
      logic [`POCC_COMP_W-1:0] res;
      logic [`POCC_COMP_W-1:0] ofs;
      res = v;
      ofs = v - `POCC_ALIAS2_LO;
      if (v >= `POCC_ALIAS1_LO && v <= `POCC_ALIAS1_HI) begin
         res = v - `POCC_ALIAS1_OFS;
      end else if (v >= `POCC_ALIAS2_LO) begin
         res = `POCC_ALIAS2_BASE + {3'h0, ofs[6:0]};
      end
      // Legal lead and lag values pass through unchanged
      return res;
   endfunction : alias_comp

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   assign idx = ADR_I[17:2];
   assign wr_en = (st_q == POCC_BUS_READ) && WE_I;
   assign comp_hit[0] = (idx == `POCC_IDX_PH_A);
   assign comp_hit[1] = (idx == `POCC_IDX_PH_B);
   assign comp_hit[2] = (idx == `POCC_IDX_PH_C);

   assign cfg_hit = (idx == `POCC_IDX_CFG);
   // Writes land in the decode cycle, on the same edge that raises ack
   assign cfg_wr = wr_en && cfg_hit;
   assign comp_wr = {3{wr_en}} & comp_hit;
   assign snap_hit = (idx >= `POCC_IDX_SNAP1) && (idx <= `POCC_IDX_SNAP3);
   assign snap_addr = snap_hit ? idx[1:0] : 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Wishbone handshake: decode, then answer one cycle later
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         st_q <= POCC_BUS_IDLE;
         ack_q <= 1'b0;
      end else begin
         case (st_q)
            POCC_BUS_IDLE: begin
               ack_q <= 1'b0;
               if (CYC_I && STB_I) begin
                  st_q <= POCC_BUS_READ;
               end
            end
            POCC_BUS_READ: begin
               // Address and data are still held by the master here
               ack_q <= 1'b1;
               st_q <= POCC_BUS_ACK;
            end
            POCC_BUS_ACK: begin
               ack_q <= 1'b0;
               st_q <= POCC_BUS_IDLE;
            end
            default: begin
               ack_q <= 1'b0;
               st_q <= POCC_BUS_IDLE;
            end
         endcase
      end
   end

   // Read mux; snapshot memory data is already registered by now
   always_comb begin
      rd_d = 32'h0000_0000;
      if (cfg_hit) begin
         rd_d = {16'h0000, cfg_q};
      end else if (comp_hit[0]) begin
         rd_d = {22'h0, comp_q[0]};
      end else if (comp_hit[1]) begin
         rd_d = {22'h0, comp_q[1]};
      end else if (comp_hit[2]) begin
         rd_d = {22'h0, comp_q[2]};
      end else if (snap_hit) begin
         rd_d = snap_rd;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         dat_q <= 32'h0000_0000;
      end else if (st_q == POCC_BUS_READ) begin
         dat_q <= WE_I ? 32'h0000_0000 : rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration register
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         cfg_q <= `POCC_CFG_RST;
      end else if (cfg_wr) begin
         cfg_q <= merge16(cfg_q, DAT_I, SEL_I) & `POCC_CFG_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase compensation, one register per phase
   genvar gp;
   generate
      for (gp = 0; gp < 3; gp++) begin : g_phase
         logic [15:0] wr_v;
         assign wr_v = merge16({6'h00, comp_q[gp]}, DAT_I, SEL_I);
         always_ff @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
               comp_q[gp] <= `POCC_COMP_RST;
            end else if (comp_wr[gp]) begin
               comp_q[gp] <= wr_v[`POCC_COMP_W-1:0];
            end
         end
         // Range limits are software's duty; out of range values alias
         always_ff @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
               comp_eff_q[gp] <= `POCC_COMP_RST;
            end else begin
               comp_eff_q[gp] <= alias_comp(comp_q[gp]);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Output three source selection
   assign src3 = pocc_src_t'(cfg_q[`POCC_SEL3_LSB +: 3]);

   always_comb begin
      p3_pow_d = '0;
      src3_ok = 1'b1;
      case (src3)
         POCC_SRC_ACT: begin
            p3_pow_d = SUM_ACT;
         end
         POCC_SRC_REACT: begin
            p3_pow_d = SUM_REACT;
         end
         POCC_SRC_APP: begin
            p3_pow_d = SUM_APP;
         end
         POCC_SRC_FACT: begin
            p3_pow_d = SUM_FACT;
         end
         POCC_SRC_FREACT: begin
            p3_pow_d = SUM_FREACT;
         end
         default: begin
            src3_ok = 1'b0;
         end
      endcase
   end

   // Power word follows the selected source every cycle
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         p3_pow_q <= '0;
      end else begin
         p3_pow_q <= p3_pow_d;
      end
   end

   // Source fields of outputs one and two go out for their datapaths
   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         src1_q <= 3'h0;
      end else begin
         src1_q <= cfg_q[`POCC_SEL1_LSB +: 3];
      end
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         src2_q <= 3'h0;
      end else begin
         src2_q <= cfg_q[`POCC_SEL2_LSB +: 3];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulse outputs and energy capture
   // A reserved source on output three blocks pin and capture alike
   assign dfc = {DFC3_PULSE & src3_ok, DFC2_PULSE, DFC1_PULSE};
   assign energy[0] = ENERGY1;
   assign energy[1] = ENERGY2;
   assign energy[2] = ENERGY3;

   genvar go;
   generate
      for (go = 0; go < 3; go++) begin : g_out
         // Converter keeps running; only the pin is gated
         always_ff @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
               pulse_q[go] <= 1'b0;
            end else begin
               pulse_q[go] <= dfc[go] & ~cfg_q[`POCC_DIS_LSB + go];
            end
         end

         // Previous level for the capture edge; idle low, so no false edge
         always_ff @(posedge CLOCK or negedge NRST) begin
            if (!NRST) begin
               dfc_q[go] <= 1'b0;
            end else begin
               dfc_q[go] <= dfc[go];
            end
         end
         assign snap_we[go] = cfg_q[`POCC_LATCH_LSB + go] &
                              dfc[go] & ~dfc_q[go];
      end
   endgenerate

   pocc_snap_mem u_snap (
      .clk(CLOCK),
      .rst_n(NRST),
      .we(snap_we),
      .wdata(energy),
      .rd_addr(snap_addr),
      .rd_data(snap_rd)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign DAT_O = dat_q;
   assign ACK_O = ack_q;
   assign PULSE_OUTPUT_1 = pulse_q[0];
   assign PULSE_OUTPUT_2 = pulse_q[1];
   assign PULSE_OUTPUT_3 = pulse_q[2];
   assign PULSE3_POWER = p3_pow_q;
   assign PULSE1_SOURCE = src1_q;
   assign PULSE2_SOURCE = src2_q;
   assign PHASE_A_COMP_EFF = comp_eff_q[0];
   assign PHASE_B_COMP_EFF = comp_eff_q[1];
   assign PHASE_C_COMP_EFF = comp_eff_q[2];

endmodule : pocc_top

// file: pocc_assertions.sv
`timescale 1ns/100ps
`include "pocc_params.svh"

module pocc_chk (
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic ACK_O,
   input wire logic DFC1_PULSE,
   input wire logic DFC2_PULSE,
   input wire logic DFC3_PULSE,
   input wire logic PULSE_OUTPUT_1,
   input wire logic PULSE_OUTPUT_2,
   input wire logic PULSE_OUTPUT_3,
   input wire logic [`POCC_COMP_W-1:0] PHASE_A_COMP_EFF,
   input wire logic [`POCC_COMP_W-1:0] PHASE_B_COMP_EFF,
   input wire logic [`POCC_COMP_W-1:0] PHASE_C_COMP_EFF
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   ////////////////////////////////
   AST_ACK_ONE: assert property (ACK_O |=> !ACK_O)
      else $error("ack longer than one cycle");
   AST_ACK_LAT: assert property ($rose(CYC_I && STB_I) |-> ##2 ACK_O)
      else $error("no ack in time");
   AST_ACK_IDLE: assert property (!(CYC_I && STB_I) |-> !ACK_O)
      else $error("ack without request");
   AST_PIN1: assert property (PULSE_OUTPUT_1 |-> $past(DFC1_PULSE))
      else $error("output one pulse without converter");
   AST_PIN2: assert property (PULSE_OUTPUT_2 |-> $past(DFC2_PULSE))
      else $error("output two pulse without converter");
   AST_PIN3: assert property (PULSE_OUTPUT_3 |-> $past(DFC3_PULSE))
      else $error("output three pulse without converter");
   AST_COMP_A: assert property (PHASE_A_COMP_EFF < 10'h240)
      else $error("phase a value not folded");
   AST_COMP_B: assert property (PHASE_B_COMP_EFF < 10'h240)
      else $error("phase b value not folded");
   AST_COMP_C: assert property (PHASE_C_COMP_EFF < 10'h240)
      else $error("phase c value not folded");
endmodule : pocc_chk

bind pocc_top pocc_chk i_chk (.CLOCK(CLOCK), .NRST(NRST), .CYC_I(CYC_I),
   .STB_I(STB_I), .ACK_O(ACK_O), .DFC1_PULSE(DFC1_PULSE),
   .DFC2_PULSE(DFC2_PULSE), .DFC3_PULSE(DFC3_PULSE),
   .PULSE_OUTPUT_1(PULSE_OUTPUT_1), .PULSE_OUTPUT_2(PULSE_OUTPUT_2),
   .PULSE_OUTPUT_3(PULSE_OUTPUT_3), .PHASE_A_COMP_EFF(PHASE_A_COMP_EFF),
   .PHASE_B_COMP_EFF(PHASE_B_COMP_EFF), .PHASE_C_COMP_EFF(PHASE_C_COMP_EFF));

// file: pocc_pulse_counter.sv
`timescale 1ns/100ps

module pocc_pulse_counter (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] pins,
   output logic [15:0] count [3]
);
   logic [2:0] pins_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_q <= 3'h0;
         count <= '{default: 16'h0};
      end else begin
         pins_q <= pins;
         for (int i = 0; i < 3; i++) begin
            if (pins[i] && !pins_q[i]) begin
               count[i] <= count[i] + 16'h1;
            end
         end
      end
   end
endmodule : pocc_pulse_counter

// file: tb_pulse_output_phase_cal_config.sv
`timescale 1ns/100ps
`include "pocc_params.svh"

module tb_pulse_output_phase_cal_config;
   logic CLOCK = 0, NRST = 0, CYC_I = 0, STB_I = 0, WE_I = 0;
   logic [17:0] ADR_I = '0;
   logic [3:0] SEL_I = '0;
   logic [31:0] DAT_I = '0, DAT_O;
   logic ACK_O, o1, o2, o3;
   logic [2:0] dfc = '0, s1, s2;
   logic [31:0] en [3] = '{default: '0};
   logic [23:0] sum [5] = '{default: '0};
   logic [23:0] p3pw;
   logic [9:0] ea, eb, ec;
   logic [15:0] cnt [3];
   logic [31:0] rdq [$];
   logic [9:0] tbl [9] = '{10'h000, 10'h17f, 10'h180, 10'h1ff, 10'h200,
      10'h23f, 10'h240, 10'h3ff, 10'h2a5};
   int n_mismatch = 0, checks_done = 0;
   int ecnt [3] = '{0, 0, 0};

   pocc_top i_dut (.CLOCK(CLOCK), .NRST(NRST), .CYC_I(CYC_I), .STB_I(STB_I),
      .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
      .ACK_O(ACK_O), .DFC1_PULSE(dfc[0]), .DFC2_PULSE(dfc[1]),
      .DFC3_PULSE(dfc[2]), .ENERGY1(en[0]), .ENERGY2(en[1]), .ENERGY3(en[2]),
      .SUM_ACT(sum[0]), .SUM_REACT(sum[1]), .SUM_APP(sum[2]),
      .SUM_FACT(sum[3]), .SUM_FREACT(sum[4]), .PULSE_OUTPUT_1(o1),
      .PULSE_OUTPUT_2(o2), .PULSE_OUTPUT_3(o3), .PULSE3_POWER(p3pw),
      .PULSE1_SOURCE(s1), .PULSE2_SOURCE(s2), .PHASE_A_COMP_EFF(ea),
      .PHASE_B_COMP_EFF(eb), .PHASE_C_COMP_EFF(ec));
   pocc_pulse_counter i_cnt (.clk(CLOCK), .rst_n(NRST), .pins({o3, o2, o1}),
      .count(cnt));

   initial begin
      forever #50 CLOCK = ~CLOCK;
   end
   ////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic wb(input logic w, input logic [15:0] idx, logic [31:0] d);
      int n;
      @(posedge CLOCK);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I <= w;
      ADR_I <= {idx, 2'b00};
      DAT_I <= d;
      SEL_I <= 4'h3;
      n = 0;
      do begin
         @(posedge CLOCK);
         n++;
      end while (ACK_O !== 1'b1 && n < 20);
      if (ACK_O !== 1'b1) begin
         n_mismatch++;
         end_of_test();
      end
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      WE_I <= 1'b0;
   endtask : wb

   task automatic rd(input logic [15:0] idx, input logic [31:0] e);
      rdq.push_back(e);
      wb(1'b0, idx, 32'h0);
   endtask : rd

   // Oldest expected read value is matched against each read answer
   always @(posedge CLOCK) begin
      if (ACK_O === 1'b1 && WE_I === 1'b0) begin
         if (rdq.size() == 0) begin
            check("read queue", 32'h1, 32'h0);
         end else begin
            check("read data", DAT_O, rdq.pop_front());
         end
      end
   end

   function automatic logic [9:0] fold(input logic [9:0] v);
      if (v >= 10'h240) return 10'h180 + ((v - 10'h240) & 10'h07f);
      if (v >= 10'h180 && v < 10'h200) return v - 10'h080;
      return v;
   endfunction : fold
   ////////////////////////////////
   initial begin
      int i, k;
      logic [31:0] c, e [3];
      logic [15:0] cfg;
      logic [2:0] r, g;
      void'($urandom(32'h1588a6fc));
      repeat (2) @(posedge CLOCK);
      NRST <= 1'b1;
      rd(`POCC_IDX_CFG, 32'h0e00);
      for (i = 0; i < 3; i++) rd(`POCC_IDX_PH_A + 16'(i), 32'h0);
      rd(16'h0100, 32'h0);
      wb(1'b1, `POCC_IDX_CFG, 32'hffff);
      rd(`POCC_IDX_CFG, 32'h7fff);
      for (i = 0; i < 9; i++) begin
         c = $urandom;
         wb(1'b1, `POCC_IDX_PH_A, {22'h3fffff, tbl[i]});
         wb(1'b1, `POCC_IDX_PH_B, {22'h0, tbl[8 - i]});
         wb(1'b1, `POCC_IDX_PH_C, c);
         rd(`POCC_IDX_PH_A, {22'h0, tbl[i]});
         rd(`POCC_IDX_PH_C, {22'h0, c[9:0]});
         check("eff a", ea, fold(tbl[i]));
         check("eff b", eb, fold(tbl[8 - i]));
         check("eff c", ec, fold(c[9:0]));
      end
      for (k = 0; k < 5; k++) sum[k] <= 24'($urandom);
      for (i = 0; i < 64; i++) begin
         c = i;
         cfg = {4'h0, c[5:3], c[2:0], 6'($urandom)};
         wb(1'b1, `POCC_IDX_CFG, {16'h0, cfg});
         r = 3'($urandom);
         dfc <= r;
         repeat (2) @(posedge CLOCK);
         @(negedge CLOCK);
         g = r & ~c[5:3];
         if (c[2:0] > 3'h4) g[2] = 1'b0;
         for (k = 0; k < 3; k++) ecnt[k] += g[k];
         check("pins", {o3, o2, o1}, g);
         check("src3 power", p3pw, c[2:0] > 4 ? 24'h0 : sum[c[2:0]]);
         check("src1", s1, cfg[2:0]);
         check("src2", s2, cfg[5:3]);
         @(posedge CLOCK);
         dfc <= 3'h0;
      end
      repeat (3) @(posedge CLOCK);
      for (k = 0; k < 3; k++) check("count", cnt[k], ecnt[k]);
      for (k = 0; k < 3; k++) en[k] <= $urandom;
      wb(1'b1, `POCC_IDX_CFG, 32'h5e00);
      e = en;
      dfc <= 3'h7;
      @(posedge CLOCK);
      dfc <= 3'h0;
      @(posedge CLOCK);
      for (k = 0; k < 3; k++) en[k] <= $urandom;
      rd(`POCC_IDX_SNAP1, e[0]);
      rd(`POCC_IDX_SNAP2, 32'h0);
      rd(`POCC_IDX_SNAP3, e[2]);
      wb(1'b1, `POCC_IDX_CFG, 32'h4f40);
      dfc <= 3'h4;
      @(posedge CLOCK);
      dfc <= 3'h0;
      rd(`POCC_IDX_SNAP3, e[2]);
      repeat (3) @(posedge CLOCK);
      end_of_test();
   end
endmodule : tb_pulse_output_phase_cal_config
